// ===== dv/sms_chk_asserts.sv
// speed mode checker
`timescale 1ns/10ps
module sms_chk (
  // clock and reset
  input wire       sys_clk,
  input wire       rst_b,
  // control port side
  input wire       port_enable_bit,
  input wire       speed_sel_hi,
  input wire       speed_sel_lo,
  // status
  input wire [1:0] speed_mode_r,
  input wire       auto_active_r,
  input wire       ctrl_mode_r,
  input wire       standalone_r
);
  wire [1:0] sel = {speed_sel_hi, speed_sel_lo};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  chk_mode_ok: assert property (speed_mode_r != 2'h0) else $error("mode");
  chk_auto_dflt: assert property (!ctrl_mode_r |-> auto_active_r) else $error("auto");
  chk_sel_fix: assert property (ctrl_mode_r && sel != 2'h0 |=>
    speed_mode_r == $past(sel) && !auto_active_r) else $error("fix");
  chk_sel_auto: assert property (ctrl_mode_r && sel == 2'h0 |=> auto_active_r)
    else $error("sel");
  chk_port_entry: assert property (port_enable_bit && !ctrl_mode_r && !standalone_r |=>
    ctrl_mode_r) else $error("entry");
  chk_ctrl_keep: assert property (ctrl_mode_r |=> ctrl_mode_r) else $error("ctrl");
  chk_alone_lock: assert property (standalone_r && !ctrl_mode_r |=> !ctrl_mode_r)
    else $error("lock");
  chk_mode_hold: assert property (!ctrl_mode_r && $changed(speed_mode_r) |=>
    ($stable(speed_mode_r) || ctrl_mode_r)[*8]) else $error("hold");
  cover property (ctrl_mode_r && sel == 2'h3);
  cover property (standalone_r);
  cover property (speed_mode_r == 2'h2);
endmodule
bind sms_speed_mode_select sms_chk u_chk (.*);

// ===== dv/sms_fclk_src.sv
// frame clock source
`timescale 1ns/10ps
module sms_fclk_src (
  // half period in clocks, 0 holds the pin; output pin
  input  int   half_cyc,
  output logic frame_clock
);
  // clock multiples keep it synchronous, bench sets the rate
  initial frame_clock = 1'b0;
  always #10 if (half_cyc > 0) #(half_cyc * 10 - 10) frame_clock = ~frame_clock;
endmodule

// ===== dv/tb.sv
// speed mode bench
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'b0;
  logic rst_b, frame_clock, port_enable_bit, speed_sel_hi, speed_sel_lo;
  logic [1:0] speed_mode_r;
  logic auto_active_r, ctrl_mode_r, standalone_r;
  int half_cyc, n_mismatch, samples_checked;
  sms_speed_mode_select dut (.*);
  sms_fclk_src u_src (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [2:0] got, want);
    samples_checked++;
    if (got !== want) begin
      n_mismatch++;
      $display("MISMATCH %0t bad", $time);
    end
  endtask
  task automatic tally_and_finish();
    $display("%0d %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_st(input logic [2:0] w, int lim);
    int i;
    for (i = 0; i < lim && {standalone_r, speed_mode_r} !== w; i++) tick(1);
    check({standalone_r, speed_mode_r}, w);
    if (i == lim) tally_and_finish();
  endtask
  task automatic do_reset();
    {rst_b, port_enable_bit, speed_sel_hi, speed_sel_lo} = 4'h0;
    tick(8);
    rst_b = 1'b1;
  endtask
  task automatic t_auto();
    do_reset();
    half_cyc = 520;
    wait_st(3'h2, 12000);
    half_cyc = 260;
    wait_st(3'h3, 8000);
    $display("auto ok");
  endtask
  // window is still open here, quad detection is in force
  task automatic t_manual();
    port_enable_bit = 1'b1;
    for (int f = 3; f >= 0; f--) begin
      {speed_sel_hi, speed_sel_lo} = f[1:0];
      tick(2);
      check({auto_active_r, speed_mode_r}, f ? f[2:0] : 3'h7);
    end
    $display("manual ok");
  endtask
  // fast frames keep the expiry wait short
  task automatic t_alone();
    do_reset();
    half_cyc = 10;
    wait_st(3'h7, 50000);
    {port_enable_bit, speed_sel_hi, speed_sel_lo} = 3'h7;
    tick(3);
    check({ctrl_mode_r, auto_active_r, speed_mode_r[0]}, 3'h3);
    $display("alone ok");
  endtask
  initial begin
    t_auto();
    t_manual();
    t_alone();
    tally_and_finish();
  end
endmodule

// ===== inc/sms_defs.vh
// constants for the speed mode selector
`ifndef SMS_DEFS_VH
`define SMS_DEFS_VH

// speed mode codes, same coding as the two-bit select field
`define SMS_MODE_AUTO      2'h0
`define SMS_MODE_SINGLE    2'h1
`define SMS_MODE_DOUBLE    2'h2
`define SMS_MODE_QUAD      2'h3

// system clock rate in kHz (100 MHz)
`define SMS_CLK_KHZ        100000
// auto-detect lower edges of the double and quad ranges, in kHz
`define SMS_DOUBLE_MIN_KHZ 84
`define SMS_QUAD_MIN_KHZ   170
// period limits in clock cycles, longest time rounds down
`define SMS_DOUBLE_MAX_CYC (`SMS_CLK_KHZ / `SMS_DOUBLE_MIN_KHZ)
`define SMS_QUAD_MAX_CYC   (`SMS_CLK_KHZ / `SMS_QUAD_MIN_KHZ)

// frame clocks after reset release in which the port enable write is accepted
`define SMS_WIN_SINGLE     12'h200
`define SMS_WIN_DOUBLE     12'h400
`define SMS_WIN_QUAD       12'h800

// period counter width and classification stability
`define SMS_PERIOD_W       16
`define SMS_STABLE_CNT     3'h4
`define SMS_STABLE_W       3

`endif

// ===== verilog/sms_period_meter.v
// frame clock synchroniser and period meter
`timescale 1ns/10ps
`include "sms_defs.vh"

module sms_period_meter #(
  parameter PERIOD_W = `SMS_PERIOD_W
) (
  // clock and reset
  input  wire                sys_clk,
  input  wire                rst_b,
  // frame clock pin
  input  wire                frame_clock,
  // measurement
  output reg                 edge_r,
  output reg  [PERIOD_W-1:0] period_r,
  output reg                 period_ok_r
);

  reg                meta_r;
  reg                sync_r;
  reg                prev_r;
  reg [PERIOD_W-1:0] cnt_r;
  wire               rise;

  assign rise = sync_r & ~prev_r;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r      <= 1'b0;
      sync_r      <= 1'b0;
      prev_r      <= 1'b0;
      cnt_r       <= {PERIOD_W{1'b0}};
      period_r    <= {PERIOD_W{1'b0}};
      period_ok_r <= 1'b0;
      edge_r      <= 1'b0;
    end else begin
      meta_r <= frame_clock;
      sync_r <= meta_r;
      prev_r <= sync_r;
      edge_r <= rise;
      if (rise) begin
        period_r    <= cnt_r;
        // the first edge after reset already flags its period valid, though it closes no full period
        period_ok_r <= 1'b1;
        cnt_r       <= {{(PERIOD_W-1){1'b0}}, 1'b1};
      end else if (cnt_r != {PERIOD_W{1'b1}}) begin
        // saturate so the first period after a stopped frame clock reads as a very slow rate
        cnt_r <= cnt_r + {{(PERIOD_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ===== verilog/sms_speed_mode_select.v
// speed mode selector: auto detection of frame rate with manual override
`timescale 1ns/10ps
`include "sms_defs.vh"

module sms_speed_mode_select #(
  parameter PERIOD_W = `SMS_PERIOD_W
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_b,
  // frame clock pin
  input  wire       frame_clock,
  // control port side
  input  wire       port_enable_bit,
  input  wire       speed_sel_hi,
  input  wire       speed_sel_lo,
  // status
  output reg  [1:0] speed_mode_r,
  output reg        auto_active_r,
  output reg        ctrl_mode_r,
  output reg        standalone_r
);

  // meter outputs
  wire                edge_pls;
  wire [PERIOD_W-1:0] period;
  wire                period_ok;

  // detection state
  reg  [1:0]               det_mode_r;
  reg  [1:0]               det_mode_nxt;
  reg  [1:0]               cand_r;
  reg  [1:0]               cand_nxt;
  reg  [`SMS_STABLE_W-1:0] stab_r;
  reg  [`SMS_STABLE_W-1:0] stab_nxt;

  // entry window state
  reg  [1:0]               win_state_r;
  reg  [1:0]               win_state_nxt;
  reg  [11:0]              win_cnt_r;
  reg  [11:0]              win_cnt_nxt;
  reg                      ctrl_mode_nxt;
  reg                      standalone_nxt;

  // mode outputs and decode
  reg  [1:0]               speed_mode_nxt;
  reg                      auto_active_nxt;
  wire [1:0]               field;
  wire [1:0]               cls;
  wire [11:0]              win_lim;

  // entry window states
  localparam WIN_OPEN  = 2'b00;
  localparam WIN_CTRL  = 2'b01;
  localparam WIN_ALONE = 2'b10;

  sms_period_meter #(
    .PERIOD_W (PERIOD_W)
  ) u_meter (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .frame_clock (frame_clock),
    .edge_r      (edge_pls),
    .period_r    (period),
    .period_ok_r (period_ok)
  );

  // longer periods than the double range maximum are single speed;
  // rates between 50 and 84 kHz fall into single, outside any supported range
  function [1:0] classify;
    input [PERIOD_W-1:0] p;
    begin
      if (p > `SMS_DOUBLE_MAX_CYC)
        classify = `SMS_MODE_SINGLE;
      else if (p > `SMS_QUAD_MAX_CYC)
        classify = `SMS_MODE_DOUBLE;
      else
        classify = `SMS_MODE_QUAD;
    end
  endfunction

  // window length follows the mode detected so far
  function [11:0] window_len;
    input [1:0] m;
    begin
      case (m)
        `SMS_MODE_DOUBLE: window_len = `SMS_WIN_DOUBLE;
        `SMS_MODE_QUAD:   window_len = `SMS_WIN_QUAD;
        default:          window_len = `SMS_WIN_SINGLE;
      endcase
    end
  endfunction

  // a fixed field value only counts once the control port is in use
  function is_manual;
    input       ctl;
    input [1:0] sel;
    begin
      is_manual = ctl && (sel != `SMS_MODE_AUTO);
    end
  endfunction

  // one frame rise further into the entry window
  function [11:0] win_step;
    input [11:0] c;
    begin
      win_step = c + 12'h001;
    end
  endfunction

  assign field    = {speed_sel_hi, speed_sel_lo};
  assign cls      = classify(period);
  assign win_lim  = window_len(det_mode_r);

  // detection runs even under a manual override so the result is fresh on release
  always @* begin
    det_mode_nxt = det_mode_r;
    cand_nxt     = cand_r;
    stab_nxt     = stab_r;
    if (edge_pls && period_ok) begin
      if (cls != cand_r) begin
        // a new class restarts the stability run
        cand_nxt = cls;
        stab_nxt = {`SMS_STABLE_W{1'b0}};
      end else if (stab_r != `SMS_STABLE_CNT) begin
        stab_nxt = stab_r + {{(`SMS_STABLE_W-1){1'b0}}, 1'b1};
      end else begin
        // commit only after the run has been seen long enough
        det_mode_nxt = cand_r;
      end
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      det_mode_r <= `SMS_MODE_SINGLE;
      cand_r     <= `SMS_MODE_SINGLE;
      stab_r     <= {`SMS_STABLE_W{1'b0}};
    end else begin
      det_mode_r <= det_mode_nxt;
      cand_r     <= cand_nxt;
      stab_r     <= stab_nxt;
    end
  end

  // entry window for the control port after reset release;
  // a port enable in the expiry cycle still wins
  always @* begin
    win_state_nxt  = win_state_r;
    win_cnt_nxt    = win_cnt_r;
    ctrl_mode_nxt  = ctrl_mode_r;
    standalone_nxt = standalone_r;
    case (win_state_r)
      WIN_OPEN: begin
        if (port_enable_bit) begin
          win_state_nxt = WIN_CTRL;
          ctrl_mode_nxt = 1'b1;
        end else if (win_cnt_r >= win_lim) begin
          win_state_nxt  = WIN_ALONE;
          standalone_nxt = 1'b1;
        end else if (edge_pls) begin
          // only counted frame rises advance the window
          win_cnt_nxt = win_step(win_cnt_r);
        end
      end
      WIN_CTRL: begin
        // port enable is sticky until reset
        ctrl_mode_nxt = 1'b1;
      end
      WIN_ALONE: begin
        // no way back to the control port until the next reset
        standalone_nxt = 1'b1;
      end
      default: begin
        win_state_nxt = WIN_OPEN;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_state_r  <= WIN_OPEN;
      win_cnt_r    <= 12'h000;
      ctrl_mode_r  <= 1'b0;
      standalone_r <= 1'b0;
    end else begin
      win_state_r  <= win_state_nxt;
      win_cnt_r    <= win_cnt_nxt;
      ctrl_mode_r  <= ctrl_mode_nxt;
      standalone_r <= standalone_nxt;
    end
  end

  // the select field counts only in control port mode; pins cannot force a mode
  always @* begin
    if (is_manual(ctrl_mode_r, field)) begin
      speed_mode_nxt = field;
    end else begin
      speed_mode_nxt = det_mode_r;
    end
    auto_active_nxt = ~is_manual(ctrl_mode_r, field);
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_mode_r  <= `SMS_MODE_SINGLE;
      auto_active_r <= 1'b1;
    end else begin
      speed_mode_r  <= speed_mode_nxt;
      auto_active_r <= auto_active_nxt;
    end
  end

endmodule
